// File: bench/msd_asserts.sv
/*
 Pin-level checks on msd_top: strobe shapes, fetch address and data timing,
 move steering and I/O space decode.
 Assumes request fields stay stable from the request until done.
*/
`timescale 1ns/100ps
`default_nettype none
module msd_asserts (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// Configuration
	input wire logic mode_fast_in,
	input wire logic latch_strobe_disable_in,
	input wire logic in_app_program_select_in,
	input wire logic force_external_data_in,
	input wire logic flash_data_enable_in,
	input wire logic memory_write_enable_in,
	// Requests and answers
	input wire logic [15:0] code_addr_in,
	input wire logic xmove_wide_in,
	input wire logic [15:0] xmove_addr_in,
	input wire logic bus_done_out,
	input wire logic [7:0] bus_rdata_out,
	input wire logic flash_data_window_rd_out,
	input wire logic flash_data_window_wr_out,
	input wire logic [7:0] flash_data_window_addr_out,
	input wire logic ram_done_out,
	input wire logic io_req_out,
	input wire logic [7:0] io_addr_out,
	// External bus pins
	input wire logic latch_strobe_out,
	input wire logic program_read_strobe_n_out,
	input wire logic write_strobe_n_out,
	input wire logic [7:0] port2_out,
	input wire logic [7:0] port0_out,
	input wire logic port0_oe_out,
	input wire logic [7:0] port0_in
);
	default clocking dcb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	// Strobe shapes
	property p_latch_duty;
		$rose(latch_strobe_out) && !mode_fast_in && !latch_strobe_disable_in |=>
			latch_strobe_out ##1 !latch_strobe_out [*4] ##1 latch_strobe_out;
	endproperty
	a_latch_duty: assert property (p_latch_duty)
		else $error("latch strobe period or duty wrong");
	property p_latch_off;
		latch_strobe_disable_in |=> !latch_strobe_out;
	endproperty
	a_latch_off: assert property (p_latch_off)
		else $error("latch strobe toggles while disabled");
	property p_rd_duty;
		$fell(program_read_strobe_n_out) && !mode_fast_in |->
			!program_read_strobe_n_out [*3] ##1 program_read_strobe_n_out;
	endproperty
	a_rd_duty: assert property (p_rd_duty)
		else $error("read strobe low time wrong");
	property p_stretch;
		$fell(program_read_strobe_n_out) && mode_fast_in |-> !program_read_strobe_n_out [*8]
			##1 !program_read_strobe_n_out ##1 program_read_strobe_n_out;
	endproperty
	a_stretch: assert property (p_stretch)
		else $error("fast fetch not stretched threefold");
	// Fetch address and data
	property p_addr;
		$fell(program_read_strobe_n_out) |-> port2_out == code_addr_in[15:8]
			&& $past(port0_out) == code_addr_in[7:0] && !port0_oe_out;
	endproperty
	a_addr: assert property (p_addr)
		else $error("fetch address or float wrong");
	property p_sample;
		$rose(program_read_strobe_n_out) |-> $past(bus_done_out)
			&& bus_rdata_out == $past(port0_in, 2);
	endproperty
	a_sample: assert property (p_sample)
		else $error("fetched byte not taken before strobe rise");
	// Move steering
	property p_flash_data_window_map;
		flash_data_window_rd_out |-> xmove_wide_in && flash_data_enable_in && !in_app_program_select_in
			&& !force_external_data_in && xmove_addr_in[15:8] == msd_pkg::FLASH_DATA_WINDOW_PAGE
			&& flash_data_window_addr_out == xmove_addr_in[7:0];
	endproperty
	a_flash_data_window_map: assert property (p_flash_data_window_map)
		else $error("flash data read outside its window");
	property p_flash_data_window_wr;
		flash_data_window_wr_out |-> memory_write_enable_in && flash_data_enable_in
			&& flash_data_window_addr_out == xmove_addr_in[7:0];
	endproperty
	a_flash_data_window_wr: assert property (p_flash_data_window_wr)
		else $error("flash data write without both enables");
	property p_io;
		io_req_out |-> ram_done_out && io_addr_out[7];
	endproperty
	a_io: assert property (p_io)
		else $error("I/O access outside upper direct space");
	// Write data driven for the whole write strobe
	property p_wr_data;
		!write_strobe_n_out |-> port0_oe_out;
	endproperty
	a_wr_data: assert property (p_wr_data)
		else $error("write strobe low without driven data");
endmodule
bind msd_top msd_asserts chk_u (.*);
`default_nettype wire

// File: bench/msd_ext_mem.sv
/*
 External program ROM, data RAM and address latch on the multiplexed bus.
 Assumes port 2 holds the high address for the whole bus cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module msd_ext_mem (
	// Clock
	input wire logic ref_clk_in,
	// Strobes
	input wire logic latch_strobe_out,
	input wire logic program_read_strobe_n_out,
	input wire logic read_strobe_n_out,
	input wire logic write_strobe_n_out,
	// Address and data lines
	input wire logic [7:0] port2_out,
	input wire logic [7:0] port0_out,
	input wire logic port0_oe_out,
	output logic [7:0] port0_in
);
	logic [7:0] lo_addr = 8'h00;
	logic [7:0] last = 8'h00;
	logic [7:0] mem [logic [15:0]];
	// Address latch closes on the falling strobe
	always @(negedge latch_strobe_out) lo_addr <= port0_in;
	// Wire level: device, memory under a strobe, else drifting
	always @* begin
		if (port0_oe_out)
			port0_in = port0_out;
		else if (!program_read_strobe_n_out)
			port0_in = lo_addr ^ port2_out ^ 8'h5a;
		else if (!read_strobe_n_out)
			port0_in = mem.exists({port2_out, lo_addr}) ? mem[{port2_out, lo_addr}]
				: ~(lo_addr ^ port2_out ^ 8'h5a);
		else
			port0_in = ~last;
	end
	// Write data is taken while the write strobe is low
	always @(posedge ref_clk_in) begin
		last <= port0_in;
		if (!write_strobe_n_out && port0_oe_out)
			mem[{port2_out, lo_addr}] = port0_out;
	end
endmodule
`default_nettype wire

// File: bench/tb.sv
/*
 Directed bench for msd_top with the external memory model.
 Assumes msd_top and the checker are compiled alongside.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
	// Stimulus
	logic ref_clk_in = 1'b0, reset_in = 1'b1, mode_fast_in = 1'b0, flash_8k_in = 1'b0;
	logic latch_strobe_disable_in = 1'b0, signature_read_enable_in = 1'b0;
	logic in_app_program_select_in = 1'b0, force_external_data_in = 1'b0;
	logic flash_data_enable_in = 1'b0, memory_write_enable_in = 1'b0, security_lock_in = 1'b0;
	logic bank_select_low_in = 1'b0, bank_select_high_in = 1'b0, code_req_in = 1'b0;
	logic code_table_in = 1'b0, xmove_req_in = 1'b0, xmove_write_in = 1'b0;
	logic xmove_wide_in = 1'b0, ram_req_in = 1'b0, ram_write_in = 1'b0, ram_bit_wdata_in = 1'b0;
	logic [15:0] code_addr_in = 16'h0000, xmove_addr_in = 16'h0000;
	logic [7:0] xmove_wdata_in = 8'h00, ram_addr_in = 8'h00, ram_wdata_in = 8'h00;
	logic [1:0] ram_mode_in = 2'h0;
	// Design outputs and memory answers
	logic bus_done_out, flash_rd_out, sig_rd_out, sig_wr_out, flash_data_window_rd_out, flash_data_window_wr_out;
	logic latch_strobe_out, program_read_strobe_n_out, read_strobe_n_out, write_strobe_n_out;
	logic port0_oe_out, ram_done_out, ram_bit_out, io_req_out, io_write_out, io_bit_out;
	logic [15:0] flash_addr_out;
	logic [8:0] sig_addr_out;
	logic [7:0] bus_rdata_out, flash_data_in, sig_wdata_out, sig_data_in, flash_data_window_addr_out;
	logic [7:0] flash_data_window_wdata_out, flash_data_window_data_in, port2_out, port0_out, port0_in;
	logic [7:0] ram_rdata_out, io_addr_out, io_wdata_out;
	logic [2:0] io_bit_index_out;
	int failures = 0, cmp_count = 0, cyc = 0, lat = 0, n_fw = 0, n_sw = 0;
	msd_top dut_u (.*);
	msd_ext_mem mem_u (.*);
	// Internal arrays answer with address patterns
	assign flash_data_in = flash_addr_out[7:0] ^ 8'h3c;
	assign sig_data_in = sig_addr_out[7:0] ^ {sig_addr_out[8], 7'h11};
	assign flash_data_window_data_in = ~flash_data_window_addr_out;
	always #10 ref_clk_in = ~ref_clk_in;
	// Cycle limit and write pulse counts
	always @(posedge ref_clk_in) begin
		cyc++;
		n_fw += int'(flash_data_window_wr_out === 1'b1);
		n_sw += int'(sig_wr_out === 1'b1);
		if (cyc == 5000) begin
			failures++;
			close_out();
		end
	end
	task close_out;
		if (failures == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// One code or move request; reads compare their byte
	task automatic bus(input logic x, w, wd, t, input logic [15:0] a, input logic [7:0] d, e);
		@(posedge ref_clk_in);
		code_req_in <= !x;
		xmove_req_in <= x;
		code_table_in <= t;
		code_addr_in <= a;
		xmove_write_in <= w;
		xmove_wide_in <= wd;
		xmove_addr_in <= a;
		xmove_wdata_in <= d;
		lat = 0;
		do begin
			@(posedge ref_clk_in);
			code_req_in <= 1'b0;
			xmove_req_in <= 1'b0;
			lat++;
		end while (bus_done_out !== 1'b1 && lat < 100);
		if (!w) `CHK(bus_rdata_out, e)
	endtask
	// One internal RAM request
	task automatic ram(input logic [1:0] m, input logic w, input logic [7:0] a, d, e);
		@(posedge ref_clk_in);
		ram_req_in <= 1'b1;
		ram_mode_in <= m;
		ram_write_in <= w;
		ram_addr_in <= a;
		ram_wdata_in <= d;
		ram_bit_wdata_in <= d[0];
		lat = 0;
		do begin
			@(posedge ref_clk_in);
			ram_req_in <= 1'b0;
			lat++;
		end while (ram_done_out !== 1'b1 && lat < 100);
		if (!w) `CHK((m == 2'h3) ? {7'h00, ram_bit_out} : ram_rdata_out, e)
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge ref_clk_in);
		`CHK({latch_strobe_out, program_read_strobe_n_out, port0_oe_out}, 3'b010);
		reset_in <= 1'b0;
		bus(0, 0, 0, 0, 16'h0123, 8'h00, 8'h1f);
		`CHK(lat inside {[3:9]}, 1'b1);
		bus(0, 0, 0, 0, 16'h1234, 8'h00, 8'h7c);
		`CHK(lat inside {[9:14]}, 1'b1);
		flash_8k_in <= 1'b1;
		bus(0, 0, 0, 0, 16'h1234, 8'h00, 8'h08);
		bus(0, 0, 0, 0, 16'hfffe, 8'h00, 8'h5b);
		signature_read_enable_in <= 1'b1;
		bus(0, 0, 0, 1, 16'h007f, 8'h00, 8'h6e);
		bus(0, 0, 0, 1, 16'h0100, 8'h00, 8'h91);
		bus(0, 0, 0, 1, 16'h01ff, 8'h00, 8'h6e);
		bus(0, 0, 0, 1, 16'h0080, 8'h00, 8'hff);
		signature_read_enable_in <= 1'b0;
		bus(0, 0, 0, 1, 16'h007f, 8'h00, 8'h43);
		flash_data_enable_in <= 1'b1;
		bus(1, 0, 1, 0, 16'h0042, 8'h00, 8'hbd);
		bus(1, 0, 0, 0, 16'h0042, 8'h00, 8'he7);
		bus(1, 0, 1, 0, 16'h0142, 8'h00, 8'he6);
		force_external_data_in <= 1'b1;
		bus(1, 0, 1, 0, 16'h0042, 8'h00, 8'he7);
		force_external_data_in <= 1'b0;
		bus(1, 1, 1, 0, 16'h0300, 8'ha5, 8'h00);
		bus(1, 0, 1, 0, 16'h0300, 8'h00, 8'ha5);
		bus(1, 1, 0, 0, 16'h0055, 8'h3c, 8'h00);
		bus(1, 0, 0, 0, 16'h0055, 8'h00, 8'h3c);
		bus(1, 1, 1, 0, 16'h0010, 8'h11, 8'h00);
		@(posedge ref_clk_in);
		`CHK(n_fw, 0);
		memory_write_enable_in <= 1'b1;
		bus(1, 1, 1, 0, 16'h0010, 8'h11, 8'h00);
		@(posedge ref_clk_in);
		`CHK(n_fw, 1);
		flash_data_enable_in <= 1'b0;
		bus(1, 0, 1, 0, 16'h0042, 8'h00, 8'he7);
		in_app_program_select_in <= 1'b1;
		signature_read_enable_in <= 1'b1;
		security_lock_in <= 1'b1;
		bus(1, 1, 1, 0, 16'h0020, 8'h5a, 8'h00);
		bus(1, 0, 1, 0, 16'h0020, 8'h00, 8'hb1);
		security_lock_in <= 1'b0;
		bus(1, 1, 1, 0, 16'h0020, 8'h5a, 8'h00);
		@(posedge ref_clk_in);
		`CHK(n_sw, 1);
		bank_select_low_in <= 1'b1;
		bank_select_high_in <= 1'b1;
		ram(2'h0, 1'b1, 8'h03, 8'h6b, 8'h00);
		ram(2'h1, 1'b0, 8'h1b, 8'h00, 8'h6b);
		ram(2'h1, 1'b1, 8'h21, 8'h00, 8'h00);
		ram(2'h3, 1'b1, 8'h0a, 8'h01, 8'h00);
		ram(2'h1, 1'b0, 8'h21, 8'h00, 8'h04);
		ram(2'h3, 1'b0, 8'h0a, 8'h00, 8'h01);
		ram(2'h2, 1'b1, 8'h90, 8'h77, 8'h00);
		ram(2'h1, 1'b1, 8'h90, 8'h33, 8'h00);
		`CHK({io_req_out, io_write_out, io_addr_out, io_wdata_out}, 18'h39033);
		ram(2'h3, 1'b1, 8'h93, 8'h01, 8'h00);
		`CHK({io_req_out, io_bit_out, io_addr_out, io_bit_index_out}, 13'h1c83);
		ram(2'h2, 1'b0, 8'h90, 8'h00, 8'h77);
		mode_fast_in <= 1'b1;
		bus(0, 0, 0, 0, 16'h0123, 8'h00, 8'h1f);
		`CHK(lat, 3);
		bus(0, 0, 0, 0, 16'h2345, 8'h00, 8'h3c);
		`CHK(lat inside {[21:26]}, 1'b1);
		latch_strobe_disable_in <= 1'b1;
		repeat (12) @(posedge ref_clk_in);
		`CHK(latch_strobe_out, 1'b0);
		latch_strobe_disable_in <= 1'b0;
		close_out();
	end
endmodule
`default_nettype wire

// File: rtl/msd_ram.sv
/*
 256 x 8 internal RAM, one port, registered read data.
 Assumes read and write are not asked in the same cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module msd_ram (
	// Clock
	input wire logic ref_clk_in,
	// Access
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem [0:255];

	// Write port
	always_ff @(posedge ref_clk_in) begin
		if (wr_in) begin
			mem[addr_in] <= wdata_in;
		end
	end

	// Registered read, holds between reads
	always_ff @(posedge ref_clk_in) begin
		if (rd_in) begin
			rdata_out <= mem[addr_in];
		end
	end
endmodule
`default_nettype wire

// File: rtl/msd_strobe_gen.sv
/*
 Free-running bus cycle phase counter with optional wait-state stretch.
 Assumes stretch_in only changes at a cycle boundary.
*/
`timescale 1ns/100ps
`default_nettype none
module msd_strobe_gen (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// Control
	input wire logic stretch_in,
	// Phase state
	output logic [2:0] phase_out,
	output logic [1:0] wait_out,
	output logic cycle_end_out
);
	// Last ref cycle of the bus cycle
	assign cycle_end_out = (phase_out == msd_pkg::PH_LAST) &&
		(!stretch_in || wait_out == msd_pkg::FAST_WAITS);

	// Phase advance, each phase held for two extra cycles while stretched
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			phase_out <= msd_pkg::PH_FIRST;
			wait_out <= msd_pkg::WAIT_ZERO;
		end else if (stretch_in && wait_out != msd_pkg::FAST_WAITS) begin
			wait_out <= wait_out + 2'h1;
		end else begin
			wait_out <= msd_pkg::WAIT_ZERO;
			phase_out <= (phase_out == msd_pkg::PH_LAST) ? msd_pkg::PH_FIRST :
				phase_out + 3'h1;
		end
	end
endmodule
`default_nettype wire

// File: rtl/msd_top.sv
/*
 Memory space decoder and multiplexed external bus for an 8-bit core:
 program fetch steering, signature windows, external data moves and the
 internal RAM bank, bit, indirect and I/O space decode.
 Assumes ref_clk_in is twice the system clock, requests are held stable
 while taken, and the core waits for done before the next request.
*/
// How it works
// - Always drive full sixteen-bit program address
// - High byte Port 2, low byte muxed Port 0
// - Latch strobe at third rate, third duty
// - Program read strobe same rate, half duty
// - Address mid latch pulse, float at strobe
// - Sample instruction just before read strobe rises
// - Same fetch timing; compat external equals internal (external here takes one bus cycle more)
// - Fast mode external fetch adds two waits
// - Disable control stops latch strobe toggling
// - Beyond internal flash fetch from external memory
// - Signature enable redirects code table reads
// - User sig 0100h-01FFh, factory 0000h-007Fh
// - Security blocks signature writes, reads allowed
// - Program select plus signature: wide moves hit sig
// - Low 32 bytes: four banks via bank bits
// - Bit addresses map to bytes 20H-2FH
// - All 256 bytes indirect; stack lives there
// - Direct 80H-FFH is I/O; indirect is RAM
// - External data over muxed bus, both pointers
// - Mapped range internal, above it external
// - Force external sends every move to bus
// - Flash data enable maps 0000H-00FFH wide moves
// - Narrow pointer moves always go external
// - Flash data writes need both enables
`timescale 1ns/100ps
`default_nettype none
module msd_top (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// Configuration
	input wire logic mode_fast_in,
	input wire logic flash_8k_in,
	input wire logic latch_strobe_disable_in,
	input wire logic signature_read_enable_in,
	input wire logic in_app_program_select_in,
	input wire logic force_external_data_in,
	input wire logic flash_data_enable_in,
	input wire logic memory_write_enable_in,
	input wire logic security_lock_in,
	input wire logic bank_select_low_in,
	input wire logic bank_select_high_in,
	// Code requests (fetch or table read)
	input wire logic code_req_in,
	input wire logic code_table_in,
	input wire logic [15:0] code_addr_in,
	// External move requests
	input wire logic xmove_req_in,
	input wire logic xmove_write_in,
	input wire logic xmove_wide_in,
	input wire logic [15:0] xmove_addr_in,
	input wire logic [7:0] xmove_wdata_in,
	// Shared answer of code and move requests
	output logic bus_done_out,
	output logic [7:0] bus_rdata_out,
	// Internal flash and signature array ports
	output logic flash_rd_out,
	output logic [15:0] flash_addr_out,
	input wire logic [7:0] flash_data_in,
	output logic sig_rd_out,
	output logic sig_wr_out,
	output logic [8:0] sig_addr_out,
	output logic [7:0] sig_wdata_out,
	input wire logic [7:0] sig_data_in,
	output logic flash_data_window_rd_out,
	output logic flash_data_window_wr_out,
	output logic [7:0] flash_data_window_addr_out,
	output logic [7:0] flash_data_window_wdata_out,
	input wire logic [7:0] flash_data_window_data_in,
	// External bus pins
	output logic latch_strobe_out,
	output logic program_read_strobe_n_out,
	output logic read_strobe_n_out,
	output logic write_strobe_n_out,
	output logic [7:0] port2_out,
	output logic [7:0] port0_out,
	output logic port0_oe_out,
	input wire logic [7:0] port0_in,
	// Internal RAM requests
	input wire logic ram_req_in,
	input wire logic [1:0] ram_mode_in,
	input wire logic ram_write_in,
	input wire logic [7:0] ram_addr_in,
	input wire logic [7:0] ram_wdata_in,
	input wire logic ram_bit_wdata_in,
	output logic ram_done_out,
	output logic [7:0] ram_rdata_out,
	output logic ram_bit_out,
	// I/O register space requests
	output logic io_req_out,
	output logic io_write_out,
	output logic io_bit_out,
	output logic [7:0] io_addr_out,
	output logic [2:0] io_bit_index_out,
	output logic [7:0] io_wdata_out
);
	msd_pkg::msd_bus_state_t bus_state;
	msd_pkg::msd_kind_t kind;
	msd_pkg::msd_src_t src;
	msd_pkg::msd_ram_state_t ram_state;
	logic [15:0] ext_addr;
	logic [7:0] ext_wdata;
	logic [2:0] phase;
	logic [1:0] wait_cnt;
	logic cycle_end;
	logic stretch;
	logic [15:0] flash_top;
	logic code_internal;
	logic sig_fact_hit;
	logic sig_user_hit;
	logic mv_sig;
	logic mv_flash_data_window;
	logic [7:0] ram_byte;
	logic [2:0] ram_bit_idx;
	logic ram_to_io;
	logic ram_take;
	logic ram_rd;
	logic ram_wr;
	logic [7:0] ram_addr;
	logic [7:0] ram_wdata;
	logic [7:0] held_addr;
	logic [2:0] held_idx;
	logic held_write;
	logic held_bit;
	logic [7:0] ram_q;

	// Stretch only external fetch cycles in fast mode
	assign stretch = mode_fast_in && bus_state == msd_pkg::BUS_EXT &&
		kind == msd_pkg::KIND_FETCH;

	msd_strobe_gen u_strobe (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.stretch_in(stretch),
		.phase_out(phase),
		.wait_out(wait_cnt),
		.cycle_end_out(cycle_end)
	);

	// Code space decode
	assign flash_top = flash_8k_in ? msd_pkg::FLASH_TOP_8K : msd_pkg::FLASH_TOP_4K;
	assign code_internal = code_addr_in < flash_top;
	assign sig_fact_hit = code_addr_in <= msd_pkg::SIG_FACT_LAST;
	assign sig_user_hit = code_addr_in >= msd_pkg::SIG_USER_FIRST &&
		code_addr_in <= msd_pkg::SIG_USER_LAST;

	// Move space decode, forcing external overrides all mapping
	assign mv_sig = !force_external_data_in && xmove_wide_in &&
		in_app_program_select_in && signature_read_enable_in;
	assign mv_flash_data_window = !force_external_data_in && xmove_wide_in &&
		!in_app_program_select_in && flash_data_enable_in &&
		xmove_addr_in[15:8] == msd_pkg::FLASH_DATA_WINDOW_PAGE;

	// Bus request handling and cycle sequencing
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			bus_state <= msd_pkg::BUS_IDLE;
			kind <= msd_pkg::KIND_FETCH;
			src <= msd_pkg::SRC_CODE;
			ext_addr <= 16'h0000;
			ext_wdata <= 8'h00;
			bus_done_out <= 1'b0;
			bus_rdata_out <= 8'h00;
			flash_rd_out <= 1'b0;
			flash_addr_out <= 16'h0000;
			sig_rd_out <= 1'b0;
			sig_wr_out <= 1'b0;
			sig_addr_out <= 9'h000;
			sig_wdata_out <= 8'h00;
			flash_data_window_rd_out <= 1'b0;
			flash_data_window_wr_out <= 1'b0;
			flash_data_window_addr_out <= 8'h00;
			flash_data_window_wdata_out <= 8'h00;
		end else begin
			bus_done_out <= 1'b0;
			flash_rd_out <= 1'b0;
			sig_rd_out <= 1'b0;
			sig_wr_out <= 1'b0;
			flash_data_window_rd_out <= 1'b0;
			flash_data_window_wr_out <= 1'b0;
			unique case (bus_state)
				msd_pkg::BUS_IDLE: begin
					if (code_req_in) begin
						ext_addr <= code_addr_in;
						kind <= msd_pkg::KIND_FETCH;
						if (code_table_in && signature_read_enable_in) begin
							sig_addr_out <= code_addr_in[8:0];
							src <= msd_pkg::SRC_SIG;
							if (sig_fact_hit || sig_user_hit) begin
								sig_rd_out <= 1'b1;
								bus_state <= msd_pkg::BUS_INT;
							end else begin
								bus_rdata_out <= 8'hff;
								bus_done_out <= 1'b1;
							end
						end else if (code_internal) begin
							flash_rd_out <= 1'b1;
							flash_addr_out <= code_addr_in;
							src <= msd_pkg::SRC_CODE;
							bus_state <= msd_pkg::BUS_INT;
						end else begin
							bus_state <= msd_pkg::BUS_PEND;
						end
					end else if (xmove_req_in) begin
						ext_addr <= xmove_addr_in;
						ext_wdata <= xmove_wdata_in;
						kind <= xmove_write_in ? msd_pkg::KIND_WRITE : msd_pkg::KIND_READ;
						sig_addr_out <= {1'b1, xmove_addr_in[7:0]};
						sig_wdata_out <= xmove_wdata_in;
						flash_data_window_addr_out <= xmove_addr_in[7:0];
						flash_data_window_wdata_out <= xmove_wdata_in;
						if (mv_sig) begin
							src <= msd_pkg::SRC_SIG;
							if (xmove_write_in) begin
								sig_wr_out <= !security_lock_in;
								bus_done_out <= 1'b1;
							end else begin
								sig_rd_out <= 1'b1;
								bus_state <= msd_pkg::BUS_INT;
							end
						end else if (mv_flash_data_window) begin
							src <= msd_pkg::SRC_FLASH_DATA_WINDOW;
							if (xmove_write_in) begin
								flash_data_window_wr_out <= memory_write_enable_in;
								bus_done_out <= 1'b1;
							end else begin
								flash_data_window_rd_out <= 1'b1;
								bus_state <= msd_pkg::BUS_INT;
							end
						end else begin
							bus_state <= msd_pkg::BUS_PEND;
						end
					end
				end
				msd_pkg::BUS_INT: begin
					// Compatibility internal access ends with the current bus cycle
					if (mode_fast_in || cycle_end) begin
						unique case (src)
							msd_pkg::SRC_CODE: bus_rdata_out <= flash_data_in;
							msd_pkg::SRC_SIG: bus_rdata_out <= sig_data_in;
							msd_pkg::SRC_FLASH_DATA_WINDOW: bus_rdata_out <= flash_data_window_data_in;
						endcase
						bus_done_out <= 1'b1;
						bus_state <= msd_pkg::BUS_IDLE;
					end
				end
				msd_pkg::BUS_PEND: begin
					if (cycle_end) begin
						bus_state <= msd_pkg::BUS_EXT;
					end
				end
				msd_pkg::BUS_EXT: begin
					if (cycle_end) begin
						if (kind != msd_pkg::KIND_WRITE) begin
							bus_rdata_out <= port0_in;
						end
						bus_done_out <= 1'b1;
						bus_state <= msd_pkg::BUS_IDLE;
					end
				end
			endcase
		end
	end

	// Latch strobe runs in every cycle unless disabled
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			latch_strobe_out <= 1'b0;
		end else begin
			latch_strobe_out <= !latch_strobe_disable_in && phase < msd_pkg::PH_ADDR + 3'h1;
		end
	end

	// Address, data and strobes of an external cycle
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			program_read_strobe_n_out <= 1'b1;
			read_strobe_n_out <= 1'b1;
			write_strobe_n_out <= 1'b1;
			port2_out <= 8'h00;
			port0_out <= 8'h00;
			port0_oe_out <= 1'b0;
		end else begin
			program_read_strobe_n_out <= !(bus_state == msd_pkg::BUS_EXT &&
				kind == msd_pkg::KIND_FETCH && phase >= msd_pkg::PH_STROBE);
			read_strobe_n_out <= !(bus_state == msd_pkg::BUS_EXT &&
				kind == msd_pkg::KIND_READ && phase >= msd_pkg::PH_STROBE);
			write_strobe_n_out <= !(bus_state == msd_pkg::BUS_EXT &&
				kind == msd_pkg::KIND_WRITE && phase >= msd_pkg::PH_STROBE);
			if (bus_state == msd_pkg::BUS_EXT) begin
				port2_out <= ext_addr[15:8];
				if (phase == msd_pkg::PH_ADDR) begin
					port0_out <= ext_addr[7:0];
					port0_oe_out <= 1'b1;
				end else if (phase == msd_pkg::PH_STROBE) begin
					port0_out <= ext_wdata;
					port0_oe_out <= kind == msd_pkg::KIND_WRITE;
				end
			end else begin
				port0_oe_out <= 1'b0;
			end
		end
	end

	// Internal RAM address decode
	always_comb begin
		ram_byte = ram_addr_in;
		ram_bit_idx = 3'h0;
		ram_to_io = 1'b0;
		unique case (ram_mode_in)
			msd_pkg::RM_REG: begin
				ram_byte = {3'h0, bank_select_high_in, bank_select_low_in,
					ram_addr_in[2:0]};
			end
			msd_pkg::RM_DIRECT: begin
				ram_to_io = ram_addr_in[msd_pkg::IO_SPACE_BIT];
			end
			msd_pkg::RM_INDIRECT: begin
				ram_byte = ram_addr_in;
			end
			msd_pkg::RM_BIT: begin
				ram_bit_idx = ram_addr_in[2:0];
				ram_to_io = ram_addr_in[msd_pkg::IO_SPACE_BIT];
				ram_byte = ram_to_io ? {ram_addr_in[7:3], 3'h0} :
					msd_pkg::BIT_AREA_BASE + {4'h0, ram_addr_in[6:3]};
			end
		endcase
	end

	// RAM port steering; bit writes are read, modify, write
	assign ram_take = ram_req_in && ram_state == msd_pkg::RS_IDLE && !ram_to_io;
	assign ram_rd = ram_take && (ram_mode_in == msd_pkg::RM_BIT || !ram_write_in);
	assign ram_wr = (ram_take && ram_mode_in != msd_pkg::RM_BIT && ram_write_in) ||
		(ram_state == msd_pkg::RS_BIT && held_write);
	assign ram_addr = ram_state == msd_pkg::RS_BIT ? held_addr : ram_byte;
	always_comb begin
		ram_wdata = ram_wdata_in;
		if (ram_state == msd_pkg::RS_BIT) begin
			ram_wdata = ram_q;
			ram_wdata[held_idx] = held_bit;
		end
	end

	msd_ram u_ram (
		.ref_clk_in(ref_clk_in),
		.rd_in(ram_rd),
		.wr_in(ram_wr),
		.addr_in(ram_addr),
		.wdata_in(ram_wdata),
		.rdata_out(ram_q)
	);
	assign ram_rdata_out = ram_q;

	// RAM and I/O request sequencing
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			ram_state <= msd_pkg::RS_IDLE;
			ram_done_out <= 1'b0;
			ram_bit_out <= 1'b0;
			held_addr <= 8'h00;
			held_idx <= 3'h0;
			held_write <= 1'b0;
			held_bit <= 1'b0;
			io_req_out <= 1'b0;
			io_write_out <= 1'b0;
			io_bit_out <= 1'b0;
			io_addr_out <= 8'h00;
			io_bit_index_out <= 3'h0;
			io_wdata_out <= 8'h00;
		end else begin
			ram_done_out <= 1'b0;
			io_req_out <= 1'b0;
			unique case (ram_state)
				msd_pkg::RS_IDLE: begin
					if (ram_req_in && ram_to_io) begin
						io_req_out <= 1'b1;
						io_write_out <= ram_write_in;
						io_bit_out <= ram_mode_in == msd_pkg::RM_BIT;
						io_addr_out <= ram_byte;
						io_bit_index_out <= ram_bit_idx;
						io_wdata_out <= ram_wdata_in;
						ram_done_out <= 1'b1;
					end else if (ram_take) begin
						held_addr <= ram_byte;
						held_idx <= ram_bit_idx;
						held_write <= ram_write_in;
						held_bit <= ram_bit_wdata_in;
						ram_state <= ram_mode_in == msd_pkg::RM_BIT ?
							msd_pkg::RS_BIT : msd_pkg::RS_BYTE;
					end
				end
				msd_pkg::RS_BYTE: begin
					ram_done_out <= 1'b1;
					ram_state <= msd_pkg::RS_IDLE;
				end
				msd_pkg::RS_BIT: begin
					ram_bit_out <= ram_q[held_idx];
					ram_done_out <= 1'b1;
					ram_state <= msd_pkg::RS_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: shared/msd_pkg.sv
/*
 Constants and types for the memory space decoder and external bus block.
 Assumes ref_clk_in runs at twice the core system clock rate, so one system
 clock is two ref_clk_in cycles and one bus cycle is six.
*/
package msd_pkg;
	// Program space limits
	localparam logic [15:0] FLASH_TOP_4K = 16'h1000;
	localparam logic [15:0] FLASH_TOP_8K = 16'h2000;
	// Signature windows
	localparam logic [15:0] SIG_FACT_LAST = 16'h007f;
	localparam logic [15:0] SIG_USER_FIRST = 16'h0100;
	localparam logic [15:0] SIG_USER_LAST = 16'h01ff;
	// Flash data page (upper address byte)
	localparam logic [7:0] FLASH_DATA_WINDOW_PAGE = 8'h00;
	// Internal RAM layout
	localparam logic [7:0] BIT_AREA_BASE = 8'h20;
	localparam int IO_SPACE_BIT = 7;
	localparam int BANK_LSB = 3;
	// Bus cycle phases, in ref_clk_in cycles
	localparam logic [2:0] PH_FIRST = 3'h0;
	localparam logic [2:0] PH_ADDR = 3'h1;
	localparam logic [2:0] PH_STROBE = 3'h3;
	localparam logic [2:0] PH_LAST = 3'h5;
	localparam logic [1:0] FAST_WAITS = 2'h2;
	localparam logic [1:0] WAIT_ZERO = 2'h0;
	// Bus state machine
	typedef enum logic [3:0] {
		BUS_IDLE = 4'h1,
		BUS_INT = 4'h2,
		BUS_PEND = 4'h4,
		BUS_EXT = 4'h8
	} msd_bus_state_t;
	// Kind of external cycle
	typedef enum logic [2:0] {
		KIND_FETCH = 3'h1,
		KIND_READ = 3'h2,
		KIND_WRITE = 3'h4
	} msd_kind_t;
	// Source of an internal read
	typedef enum logic [2:0] {
		SRC_CODE = 3'h1,
		SRC_SIG = 3'h2,
		SRC_FLASH_DATA_WINDOW = 3'h4
	} msd_src_t;
	// Internal RAM addressing mode (encoded input)
	typedef enum logic [1:0] {
		RM_REG = 2'h0,
		RM_DIRECT = 2'h1,
		RM_INDIRECT = 2'h2,
		RM_BIT = 2'h3
	} msd_ram_mode_t;
	// RAM access state machine
	typedef enum logic [2:0] {
		RS_IDLE = 3'h1,
		RS_BYTE = 3'h2,
		RS_BIT = 3'h4
	} msd_ram_state_t;
endpackage
